// ### include/pt_pkg.sv
package pt_pkg;
  // Register indices as printed; byte address is four times the index.
  localparam logic [7:0] IDX_IRQ_FLAGS   = 8'h0C;
  localparam logic [7:0] IDX_COUNT       = 8'h11;
  localparam logic [7:0] IDX_CONTROL     = 8'h12;
  localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8C;
  localparam logic [7:0] IDX_PERIOD      = 8'h92;
  localparam logic [7:0] IDX_IRQ_GLOBAL  = 8'h0B;

  localparam logic [7:0] RST_COUNT   = 8'h00;
  localparam logic [7:0] RST_PERIOD  = 8'hFF;
  localparam logic [6:0] RST_CONTROL = 7'h00;
  localparam logic [7:0] RST_IRQ     = 8'h00;

  // Control field positions.
  localparam int CTL_PS_LSB   = 0;
  localparam int CTL_RUN_BIT  = 2;
  localparam int CTL_OPS_LSB  = 3;
  // Flag and enable position of the timer match.
  localparam int IRQ_MATCH_BIT = 1;
  // Global enable register: bit 7 global, bit 6 peripheral.
  localparam int GIE_BIT  = 7;
  localparam int PERIPH_IRQ_GLOBAL_ENABLE_BIT = 6;

  // Last count of the core-cycle divider; one instruction-rate tick per four core cycles (oscillator/4).
  localparam logic [1:0] TICK_DIV_LAST = 2'h3;
endpackage : pt_pkg

// ### rtl/pt_prescaler.sv
`timescale 1ns/10ps
module pt_prescaler (
  input  wire logic       hclk,       // Core clock.
  input  wire logic       hresetn,    // Async reset, active low.
  input  wire logic       tick,       // Instruction-rate tick.
  input  wire logic       run,        // Timer running.
  input  wire logic       clr,        // Clear the prescale count.
  input  wire logic [1:0] sel,        // Prescale select.
  output logic            ptick       // Prescaled tick pulse.
);
  logic [3:0] cnt_ff;
  logic [3:0] last;

  always_comb begin
    case (sel)
      2'h0:    last = 4'h0;
      2'h1:    last = 4'h3;
      default: last = 4'hF;
    endcase
  end

  assign ptick = run && tick && !clr && (cnt_ff >= last);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 4'h0;
    end else if (clr) begin
      cnt_ff <= 4'h0;
    end else if (run && tick) begin
      cnt_ff <= (cnt_ff >= last) ? 4'h0 : cnt_ff + 4'h1;
    end
  end
endmodule : pt_prescaler

// ### rtl/pt_timer.sv
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
// How it works
// - Prescale select: 1, 4 or 16.
// - Count up, wrap to zero after period.
// - Period register read/write, resets to all ones.
// - Counter register read/write, resets to zero.
// - Postscaler passes one of N matches.
// - Postscale ratio is field plus one.
// - Postscaler event sets sticky match flag.
// - Run bit starts or stops timer.
// - Count or control write clears scalers.
// - Control write keeps counter value.
// - Match pulse goes to serial port.
// - Counter and match feed PWM.
// - Control bit 7 zero, others reset zero.
module pt_timer (
  input  wire logic        hclk,         // Core clock, 200 MHz.
  input  wire logic        hresetn,      // Async reset, active low.
  input  wire logic        hsel,         // Slave select.
  input  wire logic [31:0] haddr,        // Byte address.
  input  wire logic [1:0]  htrans,       // Transfer type.
  input  wire logic        hwrite,       // Write when high.
  input  wire logic [2:0]  hsize,        // Transfer size.
  input  wire logic [31:0] hwdata,       // Write data.
  input  wire logic        hready,       // Bus ready in.
  output logic      [31:0] hrdata,       // Read data.
  output logic             hreadyout,    // Slave ready.
  output logic             hresp,        // Always OKAY.
  output logic             match_pulse,  // Period match, to serial port.
  output logic      [7:0]  pwm_count,    // Counter, PWM time base.
  output logic             pwm_match,    // Period match, PWM time base.
  output logic             irq           // Interrupt request.
);
  logic        ph_wr_ff;
  logic [7:0]  ph_idx_ff;
  logic [7:0]  count_ff;
  logic [7:0]  period_ff;
  logic [6:0]  ctrl_ff;
  logic [7:0]  flags_ff;
  logic [7:0]  enables_ff;
  logic [7:0]  gctl_ff;
  logic [1:0]  tick_ff;
  logic [3:0]  post_ff;
  logic        tick;
  logic        ptick;
  logic        match;
  logic        post_evt;
  logic        wr_count;
  logic        wr_ctrl;
  logic        wr_flags;
  logic        scaler_clr;
  logic [7:0]  wdat;
  logic [7:0]  rsel;
  logic        addr_ok;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = (haddr[1:0] == 2'h0) && (haddr[31:10] == 22'h0);

  // Address phase capture; the data phase always completes in one cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_ff  <= 1'b0;
      ph_idx_ff <= 8'h00;
    end else if (hready) begin
      ph_wr_ff  <= hsel && htrans[1] && hwrite && addr_ok;
      ph_idx_ff <= haddr[9:2];
    end
  end

  assign wdat       = hwdata[7:0];
  assign wr_count   = ph_wr_ff && (ph_idx_ff == pt_pkg::IDX_COUNT);
  assign wr_ctrl    = ph_wr_ff && (ph_idx_ff == pt_pkg::IDX_CONTROL);
  assign wr_flags   = ph_wr_ff && (ph_idx_ff == pt_pkg::IDX_IRQ_FLAGS);
  assign scaler_clr = wr_count || wr_ctrl;

  always_comb begin
    case (haddr[9:2])
      pt_pkg::IDX_IRQ_FLAGS:   rsel = flags_ff;
      pt_pkg::IDX_COUNT:       rsel = count_ff;
      pt_pkg::IDX_CONTROL:     rsel = {1'b0, ctrl_ff};
      pt_pkg::IDX_IRQ_ENABLES: rsel = enables_ff;
      pt_pkg::IDX_PERIOD:      rsel = period_ff;
      pt_pkg::IDX_IRQ_GLOBAL:  rsel = gctl_ff;
      default:                 rsel = 8'h00;
    endcase
  end

  // Read data is registered at the address phase so it stands in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (hready) begin
      hrdata <= (hsel && htrans[1] && !hwrite && addr_ok) ? {24'h0, rsel} : 32'h0;
    end
  end

  // Instruction-rate tick: one core cycle in four, held while stopped.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_ff <= 2'h0;
    end else if (ctrl_ff[pt_pkg::CTL_RUN_BIT]) begin
      tick_ff <= tick_ff + 2'h1;
    end
  end
  assign tick = (tick_ff == pt_pkg::TICK_DIV_LAST);

  pt_prescaler u_pre (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick),
    .run     (ctrl_ff[pt_pkg::CTL_RUN_BIT]),
    .clr     (scaler_clr),
    .sel     (ctrl_ff[pt_pkg::CTL_PS_LSB +: 2]),
    .ptick   (ptick)
  );

  assign match = ptick && (count_ff == period_ff) && !wr_count;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_ff <= pt_pkg::RST_COUNT;
    end else if (wr_count) begin
      count_ff <= wdat;
    end else if (ptick) begin
      count_ff <= match ? 8'h00 : count_ff + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_ff <= pt_pkg::RST_PERIOD;
    end else if (ph_wr_ff && (ph_idx_ff == pt_pkg::IDX_PERIOD)) begin
      period_ff <= wdat;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= pt_pkg::RST_CONTROL;
    end else if (wr_ctrl) begin
      ctrl_ff <= wdat[6:0];
    end
  end

  // Postscaler counts matches; ratio is field value plus one.
  assign post_evt = match && (post_ff == ctrl_ff[pt_pkg::CTL_OPS_LSB +: 4]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      post_ff <= 4'h0;
    end else if (scaler_clr) begin
      post_ff <= 4'h0;
    end else if (match) begin
      post_ff <= post_evt ? 4'h0 : post_ff + 4'h1;
    end
  end

  // Only the timer's own flag bit is set by hardware; a set beats a same-cycle clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_ff <= pt_pkg::RST_IRQ;
    end else begin
      if (wr_flags) begin
        flags_ff <= wdat;
      end
      if (post_evt) begin
        flags_ff[pt_pkg::IRQ_MATCH_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enables_ff <= pt_pkg::RST_IRQ;
    end else if (ph_wr_ff && (ph_idx_ff == pt_pkg::IDX_IRQ_ENABLES)) begin
      enables_ff <= wdat;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gctl_ff <= pt_pkg::RST_IRQ;
    end else if (ph_wr_ff && (ph_idx_ff == pt_pkg::IDX_IRQ_GLOBAL)) begin
      gctl_ff <= wdat;
    end
  end

  assign irq = flags_ff[pt_pkg::IRQ_MATCH_BIT] && enables_ff[pt_pkg::IRQ_MATCH_BIT]
             && gctl_ff[pt_pkg::PERIPH_IRQ_GLOBAL_ENABLE_BIT] && gctl_ff[pt_pkg::GIE_BIT];

  assign match_pulse = match;
  assign pwm_match   = match;
  assign pwm_count   = count_ff;
endmodule : pt_timer

// ### bench/pt_timer_monitor.sv
`timescale 1ns/10ps
module pt_timer_monitor (
  input wire logic        hclk,        // Clock.
  input wire logic        hresetn,     // Reset.
  input wire logic        hsel,        // Select.
  input wire logic [31:0] haddr,       // Address.
  input wire logic [1:0]  htrans,      // Type.
  input wire logic        hwrite,      // Write.
  input wire logic [31:0] hwdata,      // Data in.
  input wire logic        hready,      // Ready.
  input wire logic [31:0] hrdata,      // Data out.
  input wire logic        match_pulse, // Match.
  input wire logic        pwm_match,   // Match.
  input wire logic [7:0]  pwm_count    // Count.
);
  logic wr_cnt_ff;
  logic wr_ctl_ff;
  logic rd_ctl_ff;
  wire logic ap = hsel && hready && htrans[1];
  // Flags mark the data phase, when the write lands or the read data stands.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_cnt_ff <= 1'b0;
      wr_ctl_ff <= 1'b0;
      rd_ctl_ff <= 1'b0;
    end else begin
      wr_cnt_ff <= ap && hwrite && haddr == {22'h0, pt_pkg::IDX_COUNT, 2'h0};
      wr_ctl_ff <= ap && hwrite && haddr == {22'h0, pt_pkg::IDX_CONTROL, 2'h0};
      rd_ctl_ff <= ap && !hwrite && haddr == {22'h0, pt_pkg::IDX_CONTROL, 2'h0};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_wrap; match_pulse |=> pwm_count == 8'h00; endproperty
  a_wrap: assert property (p_wrap) else $error("No wrap after match.");
  property p_space; match_pulse |=> !match_pulse [*3]; endproperty
  a_space: assert property (p_space) else $error("Matches too close.");
  property p_pwm; pwm_match == match_pulse; endproperty
  a_pwm: assert property (p_pwm) else $error("Match outputs differ.");
  property p_step; !$past(wr_cnt_ff) && $changed(pwm_count) |-> pwm_count == $past(pwm_count) + 8'h01 || pwm_count == 8'h00; endproperty
  a_step: assert property (p_step) else $error("Count jumped.");
  property p_cnt_wr; wr_cnt_ff |=> pwm_count == $past(hwdata[7:0]); endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("Count write lost.");
  property p_ctl_keep; wr_ctl_ff |=> pwm_count - $past(pwm_count) <= 8'h01 || pwm_count == 8'h00; endproperty
  a_ctl_keep: assert property (p_ctl_keep) else $error("Control write moved count.");
  property p_bit7; rd_ctl_ff |-> hrdata[31:7] == 25'h0; endproperty
  a_bit7: assert property (p_bit7) else $error("Control bit 7 set.");
  property p_rst; $rose(hresetn) |-> pwm_count == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("Count not zero after reset.");
endmodule : pt_timer_monitor

// ### bench/tb_pt_timer.sv
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; $display("[ERR] %0t got %0h want %0h", $time, g, e); end end
module tb_pt_timer;
  localparam logic [7:0] I_CNT = pt_pkg::IDX_COUNT;
  localparam logic [7:0] I_CTL = pt_pkg::IDX_CONTROL;
  localparam logic [7:0] I_PER = pt_pkg::IDX_PERIOD;
  localparam logic [7:0] I_FLG = pt_pkg::IDX_IRQ_FLAGS;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        match_pulse;
  logic [7:0]  pwm_count;
  logic        pwm_match;
  logic        irq;
  logic [31:0] rd;
  int          errors = 0;
  int          comparisons = 0;
  int          n;
  pt_timer pt_timer_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(), .match_pulse(match_pulse), .pwm_count(pwm_count), .pwm_match(pwm_match), .irq(irq));
  always #2.5 hclk = ~hclk;
  task automatic xfer(input logic [7:0] i, input logic w, input logic [7:0] d);
    haddr <= {22'h0, i, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : xfer
  task automatic rchk(input logic [7:0] i, input logic [7:0] e);
    xfer(i, 1'b0, 8'h00);
    `CHK(rd, {24'h0, e})
  endtask : rchk
  task automatic gap();
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (match_pulse !== 1'b1 && n < 2000);
  endtask : gap
  task automatic t_regs();
    rchk(I_CNT, 8'h00);
    rchk(I_PER, 8'hFF);
    rchk(I_CTL, 8'h00);
    rchk(I_FLG, 8'h00);
    rchk(8'hFF, 8'h00);
    xfer(I_PER, 1'b1, 8'h37);
    rchk(I_PER, 8'h37);
    xfer(I_CTL, 1'b1, 8'hFB);
    rchk(I_CTL, 8'h7B);
    $display("register test done");
  endtask : t_regs
  task automatic t_pre();
    int div;
    xfer(I_PER, 1'b1, 8'h02);
    for (int ps = 0; ps < 4; ps++) begin
      div = (ps == 0) ? 1 : (ps == 1) ? 4 : 16;
      xfer(I_CTL, 1'b1, 8'h04 | 8'(ps));
      gap();
      gap();
      `CHK(n, 12 * div)
    end
    $display("prescale test done");
  endtask : t_pre
  task automatic t_post();
    int nv[4] = '{1, 2, 7, 16};
    int k;
    xfer(I_PER, 1'b1, 8'h00);
    // A count left above the new period would first run round through 8'hFF.
    xfer(I_CNT, 1'b1, 8'h00);
    xfer(pt_pkg::IDX_IRQ_ENABLES, 1'b1, 8'h02);
    xfer(pt_pkg::IDX_IRQ_GLOBAL, 1'b1, 8'hC0);
    for (int j = 0; j < 4; j++) begin
      xfer(I_CTL, 1'b1, 8'h00);
      xfer(I_FLG, 1'b1, 8'h00);
      @(posedge hclk);
      `CHK(irq, 1'b0)
      xfer(I_CTL, 1'b1, {1'b0, 4'(nv[j] - 1), 3'h4});
      n = 0;
      k = 0;
      do begin
        @(posedge hclk);
        n += int'(match_pulse === 1'b1);
        k++;
      end while (irq !== 1'b1 && k < 500);
      `CHK(n, nv[j])
      repeat (8) @(posedge hclk);
      `CHK(irq, 1'b1)
    end
    $display("postscale test done");
  endtask : t_post
  task automatic t_stop();
    logic [7:0] c;
    xfer(I_PER, 1'b1, 8'hFF);
    xfer(I_CTL, 1'b1, 8'h04);
    repeat (40) @(posedge hclk);
    xfer(I_CTL, 1'b1, 8'h00);
    xfer(I_CNT, 1'b0, 8'h00);
    c = rd[7:0];
    repeat (40) @(posedge hclk);
    rchk(I_CNT, c);
    xfer(I_CTL, 1'b1, 8'h78);
    rchk(I_CNT, c);
    xfer(I_CNT, 1'b1, 8'h05);
    rchk(I_CNT, 8'h05);
    $display("stop test done");
  endtask : t_stop
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_pre();
    t_post();
    t_stop();
    conclude();
  end
  // The full run needs under 3000 cycles, so this leaves a wide margin.
  initial begin
    #100000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
endmodule : tb_pt_timer
bind pt_timer pt_timer_monitor pt_timer_monitor_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .match_pulse(match_pulse), .pwm_match(pwm_match), .pwm_count(pwm_count));
